// ---- rtl/deeac_params.svh ----
// Constants for the data EEPROM access control block.
// What this block does
// - Wait-for-interrupt or active halt request puts the block into wait.
// - Wait is entered at once when idle, else after programming or erase completes.
// - Halt enters immediately and aborts programming; during an erase it is entered only after the erase completes.
// - Array reads are not driven onto the bus while latch select is 1.
// - Array writes are not latched while latch select is 0.
// - Reset during programming leaves the targeted bytes at their old values.
// - Readout protection blocks external reads and rewrites of the array.
// - Removing protection first erases program memory and the whole array.
// - One option bit protects program memory and data array together.
// - Control/status bits 7 to 2 always read as zero.
// - Latch select set by software, cleared by hardware at cycle end.
// - Software may clear latch select only while the start flag is 0.
// - Setting the start flag begins programming of the latched bytes.
// - Start flag reads 1 while programming runs, hardware clears it at end.
// - Four calibration bytes are readable in user mode only.
// - Calibration bytes survive any erase of the array or program memory.
`ifndef DEEAC_PARAMS_SVH
`define DEEAC_PARAMS_SVH

`define DEEAC_OFS_CTRL 8'h00
`define DEEAC_OFS_IRQ_STAT 8'h04
`define DEEAC_OFS_IRQ_MASK 8'h08
`define DEEAC_OFS_OPTION 8'h0C
`define DEEAC_OFS_STATE 8'h10

`define DEEAC_BIT_PGM 0
`define DEEAC_BIT_LAT 1
`define DEEAC_CTRL_RESET 8'h00

`define DEEAC_IRQ_DONE 0
`define DEEAC_IRQ_RD_ERR 1
`define DEEAC_IRQ_WR_ERR 2
`define DEEAC_IRQ_ABORT 3
`define DEEAC_IRQ_ERASED 4
`define DEEAC_IRQ_W 5

`define DEEAC_CAL_BASE 16'hDEE0
`define DEEAC_ERASED_BYTE 8'hFF

`define DEEAC_CLK_MHZ 125
`define DEEAC_PROG_TIME_US 10
`define DEEAC_PROG_CYCLES (`DEEAC_PROG_TIME_US * `DEEAC_CLK_MHZ)

`endif

// ---- rtl/deeac_pkg.sv ----
// Types shared by the data EEPROM access control block.
package deeac_pkg;
    typedef enum logic [2:0] {
        DEEAC_IDLE = 3'h0,
        DEEAC_PROG = 3'h1,
        DEEAC_WAIT = 3'h3,
        DEEAC_HALT = 3'h2,
        DEEAC_ERASE = 3'h6
    } deeac_state_t;
endpackage

// ---- rtl/deeac_top.sv ----
// Data EEPROM control/status, array access, protection and power modes.
`timescale 1ns/1ns
`include "deeac_params.svh"
module deeac_top import deeac_pkg::*; #(
    parameter int ARR_DEPTH = 256,
    parameter int ROW_BYTES = 32,
    parameter logic [15:0] ARR_BASE = 16'h1000,
    parameter int PROG_CYCLES = `DEEAC_PROG_CYCLES,
    // Calibration contents, arbitrary values
    parameter logic [31:0] CAL_VALUES = 32'h5A5A5A5A
) (
    input wire logic clk, // 125 MHz clock
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic mem_req, // CPU array access strobe
    input wire logic mem_we, // CPU access is a write
    input wire logic mem_ext, // Access comes from outside (debug)
    input wire logic [15:0] mem_addr, // CPU byte address
    input wire logic [7:0] mem_wdata, // CPU write byte
    output logic [7:0] mem_rdata, // Read byte
    output logic mem_rdrive, // Read byte is driven on the bus
    input wire logic user_mode, // CPU runs in user mode
    input wire logic wfi_req, // Wait-for-interrupt executed
    input wire logic active_halt_req, // Active halt entered
    input wire logic halt_req, // Halt instruction executed
    input wire logic opt_readout_protect, // Option bit strap
    output logic in_wait, // Block sits in wait
    output logic in_halt, // Block sits in halt
    output logic prog_mem_erase, // Pulse: erase program memory
    output logic irq // Level interrupt
);
    localparam int AW = $clog2(ARR_DEPTH);
    localparam int RW = $clog2(ROW_BYTES);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    deeac_state_t state_q, state_d;
    logic [7:0] arr_q [ARR_DEPTH];
    logic [7:0] lat_data_q [ROW_BYTES];
    logic [ROW_BYTES-1:0] lat_vld_q;
    logic [AW-RW-1:0] lat_row_q;
    logic lat_q, pgm_q, rop_q, rop_loaded_q;
    logic [`DEEAC_IRQ_W-1:0] ists_q, imsk_q, iset;
    logic [CW-1:0] cnt_q;
    logic [AW-1:0] ers_q;
    logic [31:0] prdata_q;
    logic [7:0] mem_rdata_q;
    logic mem_rdrive_q, erase_pulse_q;

    // APB decode: zero wait states, read data captured in the setup cycle
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire hit_ctrl = paddr == `DEEAC_OFS_CTRL;
    wire hit_ists = paddr == `DEEAC_OFS_IRQ_STAT;
    wire hit_imsk = paddr == `DEEAC_OFS_IRQ_MASK;
    wire hit_opt = paddr == `DEEAC_OFS_OPTION;
    wire hit_state = paddr == `DEEAC_OFS_STATE;
    wire mapped = hit_ctrl | hit_ists | hit_imsk | hit_opt | hit_state;
    wire wr_ctrl = wr_acc & hit_ctrl;
    wire wr_opt = wr_acc & hit_opt;

    // Array and calibration decode on the CPU side
    wire [15:0] arr_off = mem_addr - ARR_BASE;
    wire [15:0] cal_off = mem_addr - `DEEAC_CAL_BASE;
    wire in_arr = (mem_addr >= ARR_BASE) && ({16'h0000, arr_off} < 32'(ARR_DEPTH));
    wire in_cal = (mem_addr >= `DEEAC_CAL_BASE) && (cal_off < 16'h0004);
    wire [AW-1:0] arr_idx = arr_off[AW-1:0];
    wire [AW-RW-1:0] row_of = arr_idx[AW-1:RW];
    wire [RW-1:0] col_of = arr_idx[RW-1:0];
    wire busy_op = (state_q == DEEAC_PROG) || (state_q == DEEAC_ERASE);
    // Array frozen while erasing or sleeping, reads then return nothing
    wire arr_open = (state_q == DEEAC_IDLE) || (state_q == DEEAC_PROG);

    wire rd_arr = mem_req & ~mem_we & in_arr;
    wire wr_arr = mem_req & mem_we & in_arr;
    wire ext_block = mem_ext & rop_q;
    wire rd_ok = rd_arr & ~lat_q & ~ext_block & arr_open;
    wire rd_cal = mem_req & ~mem_we & in_cal & user_mode & ~ext_block;
    wire lat_take = wr_arr & lat_q & ~pgm_q & ~ext_block & (state_q == DEEAC_IDLE)
        & (lat_vld_q == '0 || row_of == lat_row_q);

    // Control register writes
    wire sw_set_pgm = wr_ctrl & pwdata[`DEEAC_BIT_PGM] & lat_q & ~pgm_q
        & (state_q == DEEAC_IDLE);
    wire sw_clr_pgm = wr_ctrl & ~pwdata[`DEEAC_BIT_PGM] & pgm_q;
    wire sw_set_lat = wr_ctrl & pwdata[`DEEAC_BIT_LAT];
    wire sw_clr_lat = wr_ctrl & ~pwdata[`DEEAC_BIT_LAT] & ~pgm_q;
    wire rop_remove = wr_opt & ~pwdata[0] & rop_q & (state_q == DEEAC_IDLE);
    wire rop_set = wr_opt & pwdata[0];

    wire sleep_req = wfi_req | active_halt_req;
    wire prog_done = (state_q == DEEAC_PROG) && (cnt_q == CW'(PROG_CYCLES - 1));
    wire prog_abort = (state_q == DEEAC_PROG) && (halt_req || sw_clr_pgm);
    wire erase_done = (state_q == DEEAC_ERASE) && (ers_q == AW'(ARR_DEPTH - 1));

    function automatic logic [7:0] cal_byte(input logic [1:0] idx);
        cal_byte = CAL_VALUES[8*idx +: 8];
    endfunction

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            DEEAC_IDLE: begin
                if (halt_req) begin
                    state_d = DEEAC_HALT;
                end else if (rop_remove) begin
                    state_d = DEEAC_ERASE;
                end else if (sleep_req) begin
                    state_d = DEEAC_WAIT;
                end else if (sw_set_pgm) begin
                    state_d = DEEAC_PROG;
                end
            end
            DEEAC_PROG: begin
                if (halt_req) begin
                    state_d = DEEAC_HALT;
                end else if (prog_done) begin
                    state_d = sleep_req ? DEEAC_WAIT : DEEAC_IDLE;
                end else if (sw_clr_pgm) begin
                    state_d = DEEAC_IDLE;
                end
            end
            DEEAC_WAIT: begin
                if (halt_req) begin
                    state_d = DEEAC_HALT;
                end else if (!sleep_req) begin
                    state_d = DEEAC_IDLE;
                end
            end
            DEEAC_HALT: begin
                if (!halt_req) begin
                    state_d = DEEAC_IDLE;
                end
            end
            DEEAC_ERASE: begin
                // Erase must finish, halting here would leave protection half removed
                if (erase_done) begin
                    state_d = DEEAC_IDLE;
                end
            end
            default: begin
                state_d = DEEAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= DEEAC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Programming time counter and erase sweep index
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            ers_q <= '0;
        end else begin
            cnt_q <= (state_q == DEEAC_PROG) ? cnt_q + CW'(1) : '0;
            ers_q <= (state_q == DEEAC_ERASE) ? ers_q + AW'(1) : '0;
        end
    end

    // Control/status bits; the hardware clear at cycle end beats any set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pgm_q <= 1'(`DEEAC_CTRL_RESET >> `DEEAC_BIT_PGM);
            lat_q <= 1'b0;
        end else if (prog_done || prog_abort && halt_req) begin
            pgm_q <= 1'b0;
            lat_q <= 1'b0;
        end else begin
            if (sw_set_pgm) begin
                pgm_q <= 1'b1;
            end else if (sw_clr_pgm) begin
                pgm_q <= 1'b0;
            end
            if (sw_set_lat) begin
                lat_q <= 1'b1;
            end else if (sw_clr_lat) begin
                lat_q <= 1'b0;
            end
        end
    end

    // Write latches; emptied when a cycle ends or is cut short
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_vld_q <= '0;
            lat_row_q <= '0;
        end else if (prog_done || prog_abort) begin
            lat_vld_q <= '0;
        end else if (lat_take) begin
            lat_vld_q[col_of] <= 1'b1;
            lat_row_q <= row_of;
        end
    end
    always_ff @(posedge clk) begin
        if (lat_take) begin
            lat_data_q[col_of] <= mem_wdata;
        end
    end

    // Array cells: no reset, so a reset mid-cycle leaves old or partial data
    always_ff @(posedge clk) begin
        if (state_q == DEEAC_ERASE) begin
            arr_q[ers_q] <= `DEEAC_ERASED_BYTE;
        end else if (prog_done) begin
            for (int i = 0; i < ROW_BYTES; i++) begin
                if (lat_vld_q[i]) begin
                    arr_q[{lat_row_q, RW'(i)}] <= lat_data_q[i];
                end
            end
        end
    end

    // Protection bit caught from the strap once after reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rop_q <= 1'b0;
            rop_loaded_q <= 1'b0;
            erase_pulse_q <= 1'b0;
        end else begin
            rop_loaded_q <= 1'b1;
            erase_pulse_q <= rop_remove;
            if (!rop_loaded_q) begin
                rop_q <= opt_readout_protect;
            end else if (erase_done) begin
                rop_q <= 1'b0;
            end else if (rop_set) begin
                rop_q <= 1'b1;
            end
        end
    end

    // CPU-side read data; calibration bytes live outside the erasable array
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_rdata_q <= 8'h00;
            mem_rdrive_q <= 1'b0;
        end else begin
            mem_rdrive_q <= rd_ok | rd_cal;
            if (rd_cal) begin
                mem_rdata_q <= cal_byte(cal_off[1:0]);
            end else if (rd_ok) begin
                mem_rdata_q <= arr_q[arr_idx];
            end else begin
                mem_rdata_q <= 8'h00;
            end
        end
    end

    // Sticky interrupt status, write one to clear, a new event wins
    assign iset[`DEEAC_IRQ_DONE] = prog_done;
    assign iset[`DEEAC_IRQ_RD_ERR] = rd_arr & lat_q;
    assign iset[`DEEAC_IRQ_WR_ERR] = wr_arr & ~lat_q;
    assign iset[`DEEAC_IRQ_ABORT] = prog_abort;
    assign iset[`DEEAC_IRQ_ERASED] = erase_done;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ists_q <= '0;
            imsk_q <= '0;
        end else begin
            ists_q <= (ists_q & ~((wr_acc & hit_ists) ? pwdata[`DEEAC_IRQ_W-1:0] : '0))
                | iset;
            if (wr_acc && hit_imsk) begin
                imsk_q <= pwdata[`DEEAC_IRQ_W-1:0];
            end
        end
    end

    // Register read data, registered during the setup cycle
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, lat_q, pgm_q} :
        hit_ists ? 32'(ists_q) :
        hit_imsk ? 32'(imsk_q) :
        hit_opt ? {30'h0, (state_q == DEEAC_ERASE), rop_q} :
        hit_state ? {29'h0, state_q} : 32'h00000000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign mem_rdata = mem_rdata_q;
    assign mem_rdrive = mem_rdrive_q;
    assign in_wait = state_q == DEEAC_WAIT;
    assign in_halt = state_q == DEEAC_HALT;
    assign prog_mem_erase = erase_pulse_q;
    assign irq = |(ists_q & imsk_q);
endmodule

// ---- verification/data_eeprom_access_control_tb.sv ----
// Self-checking testbench for the data EEPROM access control block.
`timescale 1ns/1ns
`include "deeac_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module data_eeprom_access_control_tb;
    localparam logic [15:0] AB = 16'h1000;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, drv, seen_erase = 1'b0;
    logic mem_req, mem_we, mem_ext, mem_rdrive, in_wait, in_halt, prog_mem_erase, irq;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, q;
    logic user_mode = 1'b0, wfi_req = 1'b0, active_halt_req = 1'b0, halt_req = 1'b0;
    int bad_count = 0, n_tests = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (prog_mem_erase === 1'b1) seen_erase <= 1'b1;
    deeac_top #(.PROG_CYCLES(8)) deeac_top_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_ext(mem_ext), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_rdrive(mem_rdrive), .user_mode(user_mode), .wfi_req(wfi_req),
        .active_halt_req(active_halt_req), .halt_req(halt_req), .opt_readout_protect(1'b0),
        .in_wait(in_wait), .in_halt(in_halt), .prog_mem_erase(prog_mem_erase), .irq(irq));
    deeac_cpu_model deeac_cpu_model_inst (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_ext(mem_ext), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rdrive(mem_rdrive));
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin bad_count++; end_sim(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, a, 32'h0);
            if ((rd & m) === 32'h0) break;
        end
        if (i == 400) begin bad_count++; end_sim(); end
    endtask
    task automatic mem(input logic we, input logic ext, input logic [15:0] a, input logic [7:0] d);
        deeac_cpu_model_inst.access(we, ext, a, d, drv, q);
    endtask
    task automatic t_regs;
        apb(1'b1, `DEEAC_OFS_CTRL, 32'hFC);
        apb(1'b0, `DEEAC_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("slverr", 1'b1, er)
        $display("t_regs done");
    endtask
    task automatic t_program;
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h2);
        mem(1'b1, 1'b0, AB, 8'hAA);
        mem(1'b1, 1'b0, AB + 16'h1, 8'h55);
        mem(1'b0, 1'b0, AB, 8'h00);
        `CHK("rd_lat", 1'b0, drv)
        apb(1'b1, `DEEAC_OFS_IRQ_MASK, 32'h1);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h3);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h1);
        apb(1'b0, `DEEAC_OFS_CTRL, 32'h0);
        `CHK("busy", 32'h3, rd)
        poll(`DEEAC_OFS_CTRL, 32'h3);
        `CHK("irq_done", 1'b1, irq)
        mem(1'b0, 1'b0, AB + 16'h1, 8'h00);
        `CHK("byte1", 8'h55, q)
        mem(1'b1, 1'b0, AB, 8'h11);
        mem(1'b0, 1'b0, AB, 8'h00);
        `CHK("byte0", 8'hAA, q)
        apb(1'b0, `DEEAC_OFS_IRQ_STAT, 32'h0);
        `CHK("stat", 32'h7, rd & 32'h7)
        apb(1'b1, `DEEAC_OFS_IRQ_STAT, 32'h7);
        @(negedge clk);
        `CHK("irq_clr", 1'b0, irq)
        $display("t_program done");
    endtask
    task automatic t_power;
        int i;
        @(posedge clk) wfi_req <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        `CHK("wait_idle", 1'b1, in_wait)
        mem(1'b0, 1'b0, AB, 8'h00);
        `CHK("rd_wait", 1'b0, drv)
        wfi_req <= 1'b0;
        for (i = 0; i < 20 && in_wait !== 1'b0; i++) @(posedge clk);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h2);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h3);
        active_halt_req <= 1'b1;
        @(negedge clk);
        `CHK("wait_busy", 1'b0, in_wait)
        poll(`DEEAC_OFS_CTRL, 32'h3);
        @(negedge clk);
        `CHK("wait_after", 1'b1, in_wait)
        active_halt_req <= 1'b0;
        for (i = 0; i < 20 && in_wait !== 1'b0; i++) @(posedge clk);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h2);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h3);
        halt_req <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        `CHK("halt", 1'b1, in_halt)
        apb(1'b0, `DEEAC_OFS_CTRL, 32'h0);
        `CHK("abort_ctrl", 32'h0, rd)
        apb(1'b0, `DEEAC_OFS_IRQ_STAT, 32'h0);
        `CHK("abort_flag", 1'b1, rd[3])
        halt_req <= 1'b0;
        for (i = 0; i < 20 && in_halt !== 1'b0; i++) @(posedge clk);
        $display("t_power done");
    endtask
    task automatic t_protect;
        @(posedge clk) user_mode <= 1'b1;
        mem(1'b0, 1'b0, `DEEAC_CAL_BASE, 8'h00);
        `CHK("cal", 8'h5A, q)
        user_mode <= 1'b0;
        mem(1'b0, 1'b0, `DEEAC_CAL_BASE + 16'h3, 8'h00);
        `CHK("cal_sup", 1'b0, drv)
        apb(1'b1, `DEEAC_OFS_OPTION, 32'h1);
        mem(1'b0, 1'b1, AB, 8'h00);
        `CHK("ext_rd", 1'b0, drv)
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h2);
        mem(1'b1, 1'b1, AB, 8'h33);
        apb(1'b1, `DEEAC_OFS_CTRL, 32'h3);
        poll(`DEEAC_OFS_CTRL, 32'h3);
        mem(1'b0, 1'b0, AB, 8'h00);
        `CHK("ext_wr", 8'hAA, q)
        apb(1'b1, `DEEAC_OFS_OPTION, 32'h0);
        poll(`DEEAC_OFS_OPTION, 32'h3);
        `CHK("pm_erase", 1'b1, seen_erase)
        mem(1'b0, 1'b0, AB, 8'h00);
        `CHK("erased", `DEEAC_ERASED_BYTE, q)
        user_mode <= 1'b1;
        mem(1'b0, 1'b0, `DEEAC_CAL_BASE, 8'h00);
        `CHK("cal_kept", 8'h5A, q)
        $display("t_protect done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_program();
        t_power();
        t_protect();
        end_sim();
    end
endmodule

// ---- verification/deeac_checker.sv ----
// Port-level assertions for the data EEPROM access control block.
`timescale 1ns/1ns
module deeac_checker #(
    parameter int ARR_DEPTH = 256,
    parameter logic [15:0] ARR_BASE = 16'h1000
) (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic mem_req, // Array strobe
    input wire logic mem_we, // Array write
    input wire logic [15:0] mem_addr, // Array address
    input wire logic [7:0] mem_rdata, // Read byte
    input wire logic mem_rdrive, // Read byte driven
    input wire logic user_mode, // User mode
    input wire logic wfi_req, // Wait request
    input wire logic active_halt_req, // Active halt request
    input wire logic halt_req, // Halt request
    input wire logic in_wait, // Wait state
    input wire logic in_halt, // Halt state
    input wire logic prog_mem_erase // Erase pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd;
        mem_req && !mem_we;
    endsequence
    sequence s_arr_rd;
        s_rd ##0 (mem_addr >= ARR_BASE) && (int'(mem_addr) < int'(ARR_BASE) + ARR_DEPTH);
    endsequence
    sequence s_cal_rd;
        s_rd ##0 (mem_addr >= 16'hDEE0) && (mem_addr <= 16'hDEE3);
    endsequence
    property p_wait_cause;
        $rose(in_wait) |-> $past(wfi_req || active_halt_req);
    endproperty
    property p_halt_cause;
        $rose(in_halt) |-> $past(halt_req);
    endproperty
    property p_power_excl;
        !(in_wait && in_halt);
    endproperty
    property p_rd_cause;
        mem_rdrive |-> $past(mem_req && !mem_we);
    endproperty
    property p_rd_quiet;
        !mem_rdrive |-> mem_rdata == 8'h00;
    endproperty
    property p_rd_power;
        s_arr_rd ##0 (in_wait || in_halt) |=> !mem_rdrive;
    endproperty
    property p_cal_user;
        s_cal_rd ##0 !user_mode |=> !mem_rdrive;
    endproperty
    property p_ctrl_rsvd;
        psel && penable && !pwrite && paddr == 8'h00 |-> prdata[31:2] == 30'h0;
    endproperty
    property p_erase_pulse;
        $rose(prog_mem_erase) |=> !prog_mem_erase;
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("wait without request");
    a_halt_cause: assert property (p_halt_cause) else $error("halt without request");
    a_power_excl: assert property (p_power_excl) else $error("wait and halt together");
    a_rd_cause: assert property (p_rd_cause) else $error("read driven without read");
    a_rd_quiet: assert property (p_rd_quiet) else $error("read byte not zero");
    a_rd_power: assert property (p_rd_power) else $error("array read in low power");
    a_cal_user: assert property (p_cal_user) else $error("calibration read outside user");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved ctrl bits set");
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse too long");
endmodule
bind deeac_top deeac_checker #(.ARR_DEPTH(ARR_DEPTH), .ARR_BASE(ARR_BASE)) deeac_checker_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rdrive(mem_rdrive), .user_mode(user_mode), .wfi_req(wfi_req),
    .active_halt_req(active_halt_req), .halt_req(halt_req), .in_wait(in_wait),
    .in_halt(in_halt), .prog_mem_erase(prog_mem_erase));

// ---- verification/deeac_cpu_model.sv ----
// CPU core model driving the array access port.
`timescale 1ns/1ns
module deeac_cpu_model (
    input wire logic clk, // Clock
    output logic mem_req, // Access strobe
    output logic mem_we, // Write access
    output logic mem_ext, // Outside access
    output logic [15:0] mem_addr, // Byte address
    output logic [7:0] mem_wdata, // Write byte
    input wire logic [7:0] mem_rdata, // Read byte
    input wire logic mem_rdrive // Read byte driven
);
    initial begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_ext = 1'b0;
        mem_addr = 16'h0000;
        mem_wdata = 8'h00;
    end
    // Callers only use the array and the calibration bytes
    task automatic access(input logic we, input logic ext, input logic [15:0] a,
                          input logic [7:0] d, output logic drv, output logic [7:0] q);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_we <= we;
        mem_ext <= ext;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_req <= 1'b0;
        // Released lines toggle so stale values cannot pass
        mem_addr <= ~a;
        mem_wdata <= ~d;
        @(negedge clk);
        drv = mem_rdrive;
        q = mem_rdata;
    endtask
endmodule
